// *** src/thermal_monitor_regs.svh ***
`ifndef THERMAL_MONITOR_REGS_SVH
`define THERMAL_MONITOR_REGS_SVH

// register offsets
`define OFS_LOCAL_TRIP_PROG 8'h13
`define OFS_REMOTE_TRIP_PROG 8'h14
`define OFS_FACTORY_TEST 8'h15
`define OFS_LOCAL_TRIP_FIXED 8'h17
`define OFS_REMOTE_TRIP_FIXED 8'h18
`define OFS_FAN_SPEED_SETTING 8'h19
`define OFS_DIODE_TWO_TEMP 8'h20
`define OFS_DIODE_ONE_TEMP 8'h26
`define OFS_INTERNAL_TEMP 8'h27
`define OFS_DIODE_TWO_HIGH 8'h2b
`define OFS_DIODE_TWO_LOW 8'h2c
`define OFS_DIODE_ONE_HIGH 8'h37
`define OFS_DIODE_ONE_LOW 8'h38
`define OFS_INTERNAL_HIGH 8'h39
`define OFS_INTERNAL_LOW 8'h3a
`define OFS_DEVICE_CONFIG 8'h40

// configuration field positions
`define CFG_RUN_BIT 0
`define CFG_INT_ENABLE_BIT 1
`define CFG_INT_CLEAR_BIT 2
`define CFG_TRIP_LOCK_BIT 3

// reset values
`define RST_CONFIG 8'h25
`define RST_CONFIG_LOW 4'h5
`define RST_CONFIG_HIGH 4'h2
`define RST_LOCAL_TRIP 8'h46
`define RST_REMOTE_TRIP 8'h64
`define RST_FAN_SPEED 8'h00
`define RST_HIGH_LIMIT 8'h7f
`define RST_LOW_LIMIT 8'h80
`define FAN_FULL_SPEED 8'hff
`define READ_UNMAPPED 8'h00

// response latency of a register read in clock cycles
`define READ_LATENCY 1

`endif

// *** src/thermal_monitor_pkg.sv ***
package thermal_monitor_pkg;

   // two's complement temperature in degrees
   typedef logic signed [7:0] temp_t;

   // monitored channels, also the limit pair index
   typedef enum logic [1:0] {
      CH_INTERNAL = 2'b00,
      CH_DIODE_ONE = 2'b01,
      CH_DIODE_TWO = 2'b10
   } channel_t;

   localparam int NUM_CHANNELS = 3;
   localparam int NUM_LIMITS = 6;

endpackage

// *** src/limit_window_check.sv ***
module limit_window_check (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // control
   input wire logic enable,
   // measurement and limits
   input wire thermal_monitor_pkg::temp_t temp,
   input wire thermal_monitor_pkg::temp_t high_limit,
   input wire thermal_monitor_pkg::temp_t low_limit,
   // result
   output logic out_of_range
);

   logic out_of_range_ff;
   logic nxt_out_of_range;

   // standby freezes no history: the flag simply drops while idle
   always_comb begin
      nxt_out_of_range = enable && ((temp > high_limit) || (temp < low_limit));
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_of_range_ff <= 1'b0;
      end else begin
         out_of_range_ff <= nxt_out_of_range;
      end
   end

   assign out_of_range = out_of_range_ff;

endmodule

// *** src/thermal_monitor_value_registers.sv ***
// Behaviour
// - local programmable trip at 0x13, default 70, writable only while unlocked.
// - remote programmable trip at 0x14, default 100, writable only while unlocked.
// - setting config bit 3 freezes both programmable trip registers.
// - once locked, fixed trip points no longer drive overheat or fan outputs.
// - fixed trips 70 at 0x17 and 100 at 0x18 read back, never change.
// - once set, the lock bit ignores all further writes until reset.
// - fan speed setting at 0x19 is read/write, resets to zero.
// - temperatures read only: diode two 0x20, diode one 0x26, internal 0x27.
// - high/low limits at 0x2b/0x2c, 0x37/0x38, 0x39/0x3a are read/write.
// - config bit 0 runs monitoring when one, standby when zero; resets one.
// - clearing run bit does not release an asserted interrupt output.
// - config bit 1 enables the active-low interrupt output; resets zero.
// - config bit 2 holds interrupt output released, status untouched; resets one.
// - enabled but cleared: events still recorded, pin stays released.
// - lock returns to unlocked only on secondary reset or power-on reset.
// - configuration register at 0x40 powers up as 0x25.
`include "thermal_monitor_regs.svh"

module thermal_monitor_value_registers (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic secondary_reset_input_n,
   // register access from the serial bus engine
   input wire logic reg_req,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic reg_rvalid,
   output logic [7:0] reg_rdata,
   // measured temperatures from the converter
   input wire thermal_monitor_pkg::temp_t internal_temp,
   input wire thermal_monitor_pkg::temp_t diode_one_temp,
   input wire thermal_monitor_pkg::temp_t diode_two_temp,
   // interrupt status summary from the status register
   input wire logic status_pending,
   // outputs
   output logic run_mode,
   output logic [2:0] limit_violation,
   output logic overheat_output_n,
   output logic [7:0] cooling_speed_level,
   output logic int_n
);

   localparam int NCH = thermal_monitor_pkg::NUM_CHANNELS;
   localparam int NLIM = thermal_monitor_pkg::NUM_LIMITS;

   // configuration bits 3..0, trips, fan, limits
   logic [3:0] cfg_ff;
   logic [3:0] nxt_cfg;
   logic [7:0] local_trip_ff;
   logic [7:0] nxt_local_trip;
   logic [7:0] remote_trip_ff;
   logic [7:0] nxt_remote_trip;
   logic [7:0] fan_ff;
   logic [7:0] nxt_fan;
   logic [7:0] limit_ff [NLIM];
   logic [7:0] nxt_limit [NLIM];

   // read response
   logic rvalid_ff;
   logic nxt_rvalid;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   // outputs derived from state
   logic overheat_ff;
   logic nxt_overheat;
   logic [7:0] speed_ff;
   logic [7:0] nxt_speed;
   logic int_n_ff;
   logic nxt_int_n;

   logic wr;
   logic rd;
   logic locked;
   logic run;
   logic [7:0] local_trip_sel;
   logic [7:0] remote_trip_sel;
   logic trip_hit;

   assign wr = reg_req && reg_write;
   assign rd = reg_req && !reg_write;
   assign locked = cfg_ff[`CFG_TRIP_LOCK_BIT];
   assign run = cfg_ff[`CFG_RUN_BIT];

   // limit slot of an address, or -1 when the address holds no limit
   function automatic int limit_slot(input logic [7:0] addr);
      int slot;
      slot = -1;
      unique case (addr)
         `OFS_INTERNAL_HIGH: slot = 0;
         `OFS_INTERNAL_LOW: slot = 1;
         `OFS_DIODE_ONE_HIGH: slot = 2;
         `OFS_DIODE_ONE_LOW: slot = 3;
         `OFS_DIODE_TWO_HIGH: slot = 4;
         `OFS_DIODE_TWO_LOW: slot = 5;
         default: slot = -1;
      endcase
      return slot;
   endfunction

   // register write path; secondary reset outranks any write in the same cycle
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_local_trip = local_trip_ff;
      nxt_remote_trip = remote_trip_ff;
      nxt_fan = fan_ff;
      for (int i = 0; i < NLIM; i++) begin
         nxt_limit[i] = limit_ff[i];
      end
      if (!secondary_reset_input_n) begin
         nxt_cfg = `RST_CONFIG_LOW;
         nxt_local_trip = `RST_LOCAL_TRIP;
         nxt_remote_trip = `RST_REMOTE_TRIP;
      end else if (wr) begin
         if (reg_addr == `OFS_LOCAL_TRIP_PROG && !locked) begin
            nxt_local_trip = reg_wdata;
         end
         if (reg_addr == `OFS_REMOTE_TRIP_PROG && !locked) begin
            nxt_remote_trip = reg_wdata;
         end
         if (reg_addr == `OFS_FAN_SPEED_SETTING) begin
            nxt_fan = reg_wdata;
         end
         if (limit_slot(reg_addr) >= 0) begin
            nxt_limit[limit_slot(reg_addr)] = reg_wdata;
         end
         if (reg_addr == `OFS_DEVICE_CONFIG) begin
            nxt_cfg[`CFG_RUN_BIT] = reg_wdata[`CFG_RUN_BIT];
            nxt_cfg[`CFG_INT_ENABLE_BIT] = reg_wdata[`CFG_INT_ENABLE_BIT];
            nxt_cfg[`CFG_INT_CLEAR_BIT] = reg_wdata[`CFG_INT_CLEAR_BIT];
            // lock can only go from zero to one; a set lock takes no write
            nxt_cfg[`CFG_TRIP_LOCK_BIT] = locked | reg_wdata[`CFG_TRIP_LOCK_BIT];
         end
         // fixed trips, temperatures and the test register store nothing
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_ff <= `RST_CONFIG_LOW;
         local_trip_ff <= `RST_LOCAL_TRIP;
         remote_trip_ff <= `RST_REMOTE_TRIP;
         fan_ff <= `RST_FAN_SPEED;
         for (int i = 0; i < NLIM; i++) begin
            limit_ff[i] <= (i[0] ? `RST_LOW_LIMIT : `RST_HIGH_LIMIT);
         end
      end else begin
         cfg_ff <= nxt_cfg;
         local_trip_ff <= nxt_local_trip;
         remote_trip_ff <= nxt_remote_trip;
         fan_ff <= nxt_fan;
         for (int i = 0; i < NLIM; i++) begin
            limit_ff[i] <= nxt_limit[i];
         end
      end
   end

   // read mux; unmapped and test locations read zero
   always_comb begin
      nxt_rvalid = rd;
      nxt_rdata = rdata_ff;
      if (rd) begin
         nxt_rdata = `READ_UNMAPPED;
         unique case (reg_addr)
            `OFS_LOCAL_TRIP_PROG: nxt_rdata = local_trip_ff;
            `OFS_REMOTE_TRIP_PROG: nxt_rdata = remote_trip_ff;
            `OFS_LOCAL_TRIP_FIXED: nxt_rdata = `RST_LOCAL_TRIP;
            `OFS_REMOTE_TRIP_FIXED: nxt_rdata = `RST_REMOTE_TRIP;
            `OFS_FAN_SPEED_SETTING: nxt_rdata = fan_ff;
            `OFS_DIODE_TWO_TEMP: nxt_rdata = diode_two_temp;
            `OFS_DIODE_ONE_TEMP: nxt_rdata = diode_one_temp;
            `OFS_INTERNAL_TEMP: nxt_rdata = internal_temp;
            `OFS_DEVICE_CONFIG: nxt_rdata = {`RST_CONFIG_HIGH, cfg_ff};
            default: begin
               if (limit_slot(reg_addr) >= 0) begin
                  nxt_rdata = limit_ff[limit_slot(reg_addr)];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= `READ_UNMAPPED;
      end else begin
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
      end
   end

   // trip source: fixed values until locked, programmed values after
   assign local_trip_sel = locked ? local_trip_ff : `RST_LOCAL_TRIP;
   assign remote_trip_sel = locked ? remote_trip_ff : `RST_REMOTE_TRIP;

   // both diodes share the remote trip point
   assign trip_hit = ($signed(internal_temp) > $signed(local_trip_sel))
      || ($signed(diode_one_temp) > $signed(remote_trip_sel))
      || ($signed(diode_two_temp) > $signed(remote_trip_sel));

   // overheat and fan drive; trips only checked while running
   always_comb begin
      nxt_overheat = run && trip_hit;
      nxt_speed = nxt_overheat ? `FAN_FULL_SPEED : fan_ff;
   end

   // interrupt pin follows status gated by enable and clear bits; run bit is deliberately not a term
   always_comb begin
      nxt_int_n = !(cfg_ff[`CFG_INT_ENABLE_BIT] && !cfg_ff[`CFG_INT_CLEAR_BIT]
         && status_pending);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         overheat_ff <= 1'b0;
         speed_ff <= `RST_FAN_SPEED;
         int_n_ff <= 1'b1;
      end else begin
         overheat_ff <= nxt_overheat;
         speed_ff <= nxt_speed;
         int_n_ff <= nxt_int_n;
      end
   end

   // per-channel window check against the programmed limits
   for (genvar ch = 0; ch < NCH; ch++) begin : g_limit
      thermal_monitor_pkg::temp_t ch_temp;
      assign ch_temp = (ch == 0) ? internal_temp : ((ch == 1) ? diode_one_temp : diode_two_temp);
      limit_window_check u_check (
         .clk(clk),
         .arst_n(arst_n),
         .enable(run),
         .temp(ch_temp),
         .high_limit(limit_ff[2 * ch]),
         .low_limit(limit_ff[2 * ch + 1]),
         .out_of_range(limit_violation[ch])
      );
   end

   assign reg_rvalid = rvalid_ff;
   assign reg_rdata = rdata_ff;
   assign run_mode = run;
   assign overheat_output_n = !overheat_ff;
   assign cooling_speed_level = speed_ff;
   assign int_n = int_n_ff;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   AST_LOCAL_TRIP_OPEN: assert property (
      secondary_reset_input_n && wr && reg_addr == `OFS_LOCAL_TRIP_PROG && !locked
      |=> local_trip_ff == $past(reg_wdata))
      else $error("local trip not written while unlocked");

   AST_REMOTE_TRIP_OPEN: assert property (
      secondary_reset_input_n && wr && reg_addr == `OFS_REMOTE_TRIP_PROG && !locked
      |=> remote_trip_ff == $past(reg_wdata))
      else $error("remote trip not written while unlocked");

   AST_TRIP_FROZEN: assert property (
      locked && secondary_reset_input_n
      |=> $stable(local_trip_ff) && $stable(remote_trip_ff))
      else $error("programmable trip changed while locked");

   // a secondary reset sampled together with the lock may clear it on the next edge
   AST_LOCK_STICKY: assert property (
      locked && secondary_reset_input_n |=> locked)
      else $error("lock bit released without reset");

   AST_LOCK_RELEASE: assert property (
      !secondary_reset_input_n |=> cfg_ff == `RST_CONFIG_LOW)
      else $error("secondary reset did not restore configuration");

   AST_FIXED_READ: assert property (
      rd && reg_addr == `OFS_REMOTE_TRIP_FIXED |=> reg_rvalid && reg_rdata == 8'h64)
      else $error("fixed remote trip reads wrong");

   AST_FAN_WRITE: assert property (
      wr && reg_addr == `OFS_FAN_SPEED_SETTING
      |=> fan_ff == $past(reg_wdata) ##1 (overheat_ff || cooling_speed_level == $past(fan_ff)))
      else $error("fan setting not stored or not driven");

   AST_INT_CLEAR_HOLDS: assert property (
      cfg_ff[`CFG_INT_CLEAR_BIT] |=> int_n)
      else $error("interrupt driven while clear bit set");

   AST_INT_DISABLED: assert property (
      !cfg_ff[`CFG_INT_ENABLE_BIT] |=> int_n)
      else $error("interrupt driven while disabled");

   AST_INT_STAYS: assert property (
      !int_n && status_pending && cfg_ff[`CFG_INT_ENABLE_BIT] && !cfg_ff[`CFG_INT_CLEAR_BIT]
      && $fell(run) |=> !int_n)
      else $error("run bit clear released interrupt");

   AST_LOCKED_TRIP_USED: assert property (
      run && locked && $signed(internal_temp) > $signed(local_trip_ff) |=> !overheat_output_n)
      else $error("programmed local trip ignored while locked");

   AST_FIXED_IGNORED: assert property (
      run && locked && $signed(local_trip_ff) > 8'sh46 && $signed(internal_temp) > 8'sh46
      && $signed(internal_temp) <= $signed(local_trip_ff)
      && $signed(diode_one_temp) <= $signed(remote_trip_ff)
      && $signed(diode_two_temp) <= $signed(remote_trip_ff) |=> overheat_output_n)
      else $error("fixed trip still active while locked");

   AST_RO_WRITE_IGNORED: assert property (
      secondary_reset_input_n && wr && (reg_addr == `OFS_LOCAL_TRIP_FIXED
      || reg_addr == `OFS_INTERNAL_TEMP)
      |=> $stable(cfg_ff) && $stable(fan_ff) && $stable(local_trip_ff))
      else $error("read-only write disturbed state");

   // standby, config and fixed-trip read-back checks use written-out values, not the read mux; the temperature check uses $past(internal_temp)
   AST_STANDBY_QUIET: assert property (
      !run |=> limit_violation == 3'h0 && overheat_output_n)
      else $error("limit or overheat active in standby");

   AST_CONFIG_UPPER: assert property (
      rd && reg_addr == `OFS_DEVICE_CONFIG |=> reg_rvalid && reg_rdata[7:4] == 4'h2)
      else $error("configuration upper bits read wrong");

   AST_FIXED_LOCAL_READ: assert property (
      rd && reg_addr == `OFS_LOCAL_TRIP_FIXED |=> reg_rvalid && reg_rdata == 8'h46)
      else $error("fixed local trip reads wrong");

   AST_TEMP_READ: assert property (
      rd && reg_addr == `OFS_INTERNAL_TEMP |=> reg_rvalid && reg_rdata == $past(internal_temp))
      else $error("internal temperature reads wrong");

   COV_LOCK_SET: cover property (!locked ##1 locked);
   COV_OVERHEAT: cover property (overheat_output_n ##1 !overheat_output_n);
   COV_INT_ASSERT: cover property (int_n ##1 !int_n);
   COV_LIMIT_HIT: cover property (limit_violation != 3'h0);
   COV_FIXED_BYPASS: cover property (locked && $signed(local_trip_ff) > 8'sh46
      && $signed(internal_temp) > 8'sh46 && overheat_output_n);

endmodule

// *** testbench/bus_host_model.sv ***
// register bus master standing in for the serial bus engine
module bus_host_model (
   // clock
   input wire logic clk,
   // request side
   output logic reg_req,
   output logic reg_write,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   // answer side
   input wire logic reg_rvalid,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle cycles before each request, raised to act as a slow host
   int gap = 0;

   initial begin
      reg_req = 1'b0;
      reg_write = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // one access; released lines invert so stale values never look fresh
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ok);
      q = 8'h00;
      ok = 1'b1;
      if (wr && a == 8'h15) return;
      repeat (gap) @(posedge clk);
      @(posedge clk);
      reg_req <= 1'b1;
      reg_write <= wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_req <= 1'b0;
      reg_write <= ~wr;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      // read answer is due exactly one cycle after the request edge
      if (!wr) begin
         @(posedge clk);
         ok = (reg_rvalid === 1'b1);
         q = reg_rdata;
      end
   endtask
endmodule

// *** testbench/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;

   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic secondary_reset_input_n = 1'b1;
   logic status_pending = 1'b0;
   thermal_monitor_pkg::temp_t internal_temp = 8'h20;
   thermal_monitor_pkg::temp_t diode_one_temp = 8'h21;
   thermal_monitor_pkg::temp_t diode_two_temp = 8'h22;
   logic reg_req, reg_write, reg_rvalid, run_mode, overheat_output_n, int_n, ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, cooling_speed_level, q;
   logic [2:0] limit_violation;
   int mismatches = 0;
   int checks_done = 0;

   // power-up reads first, then writes each followed by a read-back
   row_t rows [27] = '{
      '{1'b0, 8'h13, 8'h00, 8'h46}, '{1'b0, 8'h14, 8'h00, 8'h64}, '{1'b0, 8'h15, 8'h00, 8'h00},
      '{1'b0, 8'h17, 8'h00, 8'h46}, '{1'b0, 8'h18, 8'h00, 8'h64}, '{1'b0, 8'h19, 8'h00, 8'h00},
      '{1'b0, 8'h40, 8'h00, 8'h25}, '{1'b0, 8'h2b, 8'h00, 8'h7f}, '{1'b0, 8'h3a, 8'h00, 8'h80},
      '{1'b0, 8'h20, 8'h00, 8'h22}, '{1'b0, 8'h26, 8'h00, 8'h21}, '{1'b0, 8'h27, 8'h00, 8'h20},
      '{1'b1, 8'h19, 8'ha5, 8'ha5}, '{1'b1, 8'h2b, 8'h55, 8'h55}, '{1'b1, 8'h2c, 8'h11, 8'h11},
      '{1'b1, 8'h37, 8'h60, 8'h60}, '{1'b1, 8'h38, 8'hf0, 8'hf0}, '{1'b1, 8'h39, 8'h50, 8'h50},
      '{1'b1, 8'h3a, 8'h05, 8'h05}, '{1'b1, 8'h13, 8'h30, 8'h30}, '{1'b1, 8'h14, 8'h40, 8'h40},
      '{1'b1, 8'h17, 8'h12, 8'h46}, '{1'b1, 8'h18, 8'h12, 8'h64}, '{1'b1, 8'h20, 8'h99, 8'h22},
      '{1'b1, 8'h26, 8'h99, 8'h21}, '{1'b1, 8'h27, 8'h99, 8'h20}, '{1'b1, 8'h50, 8'h77, 8'h00}};

   always #50 clk = ~clk;

   bus_host_model host (.clk(clk), .reg_req(reg_req), .reg_write(reg_write),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
      .reg_rdata(reg_rdata));

   thermal_monitor_value_registers uut (.clk(clk), .arst_n(arst_n),
      .secondary_reset_input_n(secondary_reset_input_n), .reg_req(reg_req),
      .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .internal_temp(internal_temp),
      .diode_one_temp(diode_one_temp), .diode_two_temp(diode_two_temp),
      .status_pending(status_pending), .run_mode(run_mode),
      .limit_violation(limit_violation), .overheat_output_n(overheat_output_n),
      .cooling_speed_level(cooling_speed_level), .int_n(int_n));

   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.access(1'b1, a, d, q, ok);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host.access(1'b0, a, 8'h00, q, ok);
      chk("reg_rvalid", 8'h01, {7'h00, ok});
      chk($sformatf("register %h", a), e, q);
   endtask

   // derived outputs trail a temperature change by one edge and a register write by two; three keeps margin
   task automatic outs(input logic [2:0] lv, input logic oh, input logic [7:0] sp,
                       input logic irq);
      repeat (3) @(posedge clk);
      chk("limit_violation", {5'h00, lv}, {5'h00, limit_violation});
      chk("overheat_output_n", {7'h00, oh}, {7'h00, overheat_output_n});
      chk("cooling_speed_level", sp, cooling_speed_level);
      chk("int_n", {7'h00, irq}, {7'h00, int_n});
   endtask

   task automatic end_of_test;
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      repeat (4000) @(posedge clk);
      mismatches++;
      end_of_test();
   end

   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 27; i++) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].exp);
      end
      // limit checks, with every limit already programmed by the table
      host.gap = 2;
      outs(3'b000, 1'b1, 8'ha5, 1'b1);
      diode_one_temp <= 8'he0;
      diode_two_temp <= 8'h56;
      outs(3'b110, 1'b1, 8'ha5, 1'b1);
      wr(8'h40, 8'h04);
      outs(3'b000, 1'b1, 8'ha5, 1'b1);
      chk("run_mode", 8'h00, {7'h00, run_mode});
      rd(8'h40, 8'h24);
      host.gap = 0;
      wr(8'h40, 8'h05);
      diode_one_temp <= 8'h21;
      diode_two_temp <= 8'h22;
      // unlocked: programmable 0x30 ignored, fixed 0x46 governs
      internal_temp <= 8'h40;
      outs(3'b000, 1'b1, 8'ha5, 1'b1);
      internal_temp <= 8'h47;
      outs(3'b000, 1'b0, 8'hff, 1'b1);
      internal_temp <= 8'h40;
      // lock, then try to undo it and to rewrite a trip point
      wr(8'h40, 8'h0d);
      rd(8'h40, 8'h2d);
      wr(8'h13, 8'h10);
      rd(8'h13, 8'h30);
      wr(8'h40, 8'h05);
      rd(8'h40, 8'h2d);
      outs(3'b000, 1'b0, 8'hff, 1'b1);
      internal_temp <= 8'h20;
      secondary_reset_input_n <= 1'b0;
      @(posedge clk);
      secondary_reset_input_n <= 1'b1;
      rd(8'h40, 8'h25);
      rd(8'h14, 8'h64);
      wr(8'h13, 8'h33);
      rd(8'h13, 8'h33);
      // relock above the fixed point: only the programmed trip may govern now
      wr(8'h13, 8'h58);
      wr(8'h40, 8'h0d);
      internal_temp <= 8'h52;
      outs(3'b001, 1'b1, 8'ha5, 1'b1);
      internal_temp <= 8'h20;
      // interrupt gating with a pending event
      status_pending <= 1'b1;
      outs(3'b000, 1'b1, 8'ha5, 1'b1);
      wr(8'h40, 8'h07);
      outs(3'b000, 1'b1, 8'ha5, 1'b1);
      wr(8'h40, 8'h03);
      outs(3'b000, 1'b1, 8'ha5, 1'b0);
      wr(8'h40, 8'h02);
      outs(3'b000, 1'b1, 8'ha5, 1'b0);
      wr(8'h40, 8'h06);
      outs(3'b000, 1'b1, 8'ha5, 1'b1);
      status_pending <= 1'b0;
      // asynchronous reset in mid-run
      wr(8'h19, 8'h3c);
      arst_n <= 1'b0;
      outs(3'b000, 1'b1, 8'h00, 1'b1);
      chk("run_mode", 8'h01, {7'h00, run_mode});
      arst_n <= 1'b1;
      rd(8'h40, 8'h25);
      rd(8'h19, 8'h00);
      rd(8'h13, 8'h46);
      end_of_test();
   end
endmodule
